// File: verilog/ucc_pkg.sv
// Purpose: Shared constants for the serial transceiver configuration block.
// Assumes: Registers sit one per 32-bit word at byte address four times the index.
// Notes:   Only bit 0 to bit 7 of each word carry data, except the 20-bit period word; upper bits read as zero.
package ucc_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_LINE   = 8'h05;
  localparam logic [7:0] IDX_RXTX   = 8'h06;
  localparam logic [7:0] IDX_FRAME  = 8'h07;
  localparam logic [7:0] IDX_MASK   = 8'h08;
  localparam logic [7:0] IDX_PERIOD = 8'h09;
  // Interrupt and line control bits.
  localparam int B_AB_ERR_IE = 2;
  localparam int B_LINE_DRV  = 0;
  // Receiver and transmitter control bits.
  localparam int B_RX_ENA     = 7;
  localparam int B_TX_ENA     = 6;
  localparam int B_SOF_DET    = 4;
  localparam int B_OPEN_DRAIN = 3;
  localparam int B_RX_MODE    = 1;
  localparam int B_MULTI_PROC = 0;
  // Frame format fields, normal and host SPI layouts.
  localparam int B_COMM_MODE  = 6;
  localparam int B_PARITY     = 4;
  localparam int B_STOP_BITS  = 3;
  localparam int B_CHAR_SIZE  = 0;
  localparam int B_DATA_ORDER = 2;
  localparam int B_CLK_PHASE  = 1;
  // Status bits, shared with the mask register.
  localparam int B_ISF = 3;
  localparam int B_BDF = 1;
  // Writable bit masks and reset values.
  localparam logic [7:0] LINE_WMASK   = 8'h05;
  localparam logic [7:0] RXTX_WMASK   = 8'hDF;
  localparam logic [7:0] STATUS_WMASK = 8'h0A;
  localparam logic [7:0] LINE_RST     = 8'h00;
  localparam logic [7:0] RXTX_RST     = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'h0A;
  localparam logic [1:0] COMM_MODE_RST = 2'h0;
  localparam logic [5:0] FRAME_RST    = 6'h03;
  localparam logic [1:0] SPI_RST      = 2'h0;
  // Field encodings.
  localparam logic [1:0] RXM_NORMAL = 2'h0;
  localparam logic [1:0] RXM_DOUBLE = 2'h1;
  localparam logic [1:0] RXM_GEN    = 2'h2;
  localparam logic [1:0] RXM_LIN    = 2'h3;
  localparam logic [1:0] CM_ASYNC   = 2'h0;
  localparam logic [1:0] CM_SYNC    = 2'h1;
  localparam logic [1:0] CM_INFRARED = 2'h2;
  localparam logic [1:0] CM_SPI     = 2'h3;
  localparam logic [2:0] CHS_9L     = 3'h6;
  localparam logic [2:0] CHS_9H     = 3'h7;
  localparam logic [3:0] BITS_BASE  = 4'h5;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;
  // Auto-baud measurement.
  localparam int         CNT_W      = 20;
  localparam logic [2:0] LAST_FALL  = 3'h3;
  localparam int         BIT_SHIFT  = 3;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: verilog/ucc_autobaud_if.sv
// Purpose: Carries mode and line to the auto-baud checker and its results back.
// Assumes: Both ends run on aclk.
// Notes:   Result strobes are single-cycle pulses.
`timescale 1ns/100ps
interface ucc_autobaud_if;
  logic                     enable;
  logic [1:0]               rx_mode;
  logic                     line;
  logic                     sync_error;
  logic                     sync_ok;
  logic [ucc_pkg::CNT_W-1:0] period;
  modport ctrl  (output enable, rx_mode, line, input sync_error, sync_ok, period);
  modport check (input enable, rx_mode, line, output sync_error, sync_ok, period);
endinterface

// File: verilog/ucc_autobaud_check.sv
// Purpose: Measures the break and sync field and judges it for auto-baud.
// Assumes: The line input is already synchronised to aclk.
// Notes:   The sync span runs from the start-bit fall to the fifth fall, eight bits.
`timescale 1ns/100ps
module ucc_autobaud_check #(
  parameter logic [ucc_pkg::CNT_W-1:0] BREAK_MIN = 20'h0_1000,
  parameter logic [ucc_pkg::CNT_W-1:0] SYNC_MIN  = 20'h0_0040,
  parameter logic [ucc_pkg::CNT_W-1:0] SYNC_MAX  = 20'h8_0000
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  ucc_autobaud_if.check ab
);
  typedef enum logic [1:0] {ST_IDLE, ST_DELIM, ST_MEASURE} ucc_ab_state_t;
  localparam int W = ucc_pkg::CNT_W;

  ucc_ab_state_t state_reg;
  logic          line_d_reg;
  logic [W-1:0]  total_reg;
  logic [W-1:0]  iv_reg;
  logic [W-1:0]  min_reg;
  logic [W-1:0]  max_reg;
  logic [2:0]    falls_reg;
  logic [W-1:0]  min_next;
  logic [W-1:0]  max_next;
  logic          bad_len;
  logic          bad_lin;

  wire active = ab.enable && ab.rx_mode[1];
  wire fall   = line_d_reg && !ab.line;

  // Judge the span; a non-0x55 character shows as uneven fall-to-fall gaps.
  always_comb begin
    min_next = (iv_reg < min_reg) ? iv_reg : min_reg;
    max_next = (iv_reg > max_reg) ? iv_reg : max_reg;
    bad_len  = (total_reg < SYNC_MIN) || (total_reg > SYNC_MAX);
    bad_lin  = (ab.rx_mode == ucc_pkg::RXM_LIN) && ((max_next - min_next) > (total_reg >> 3));
  end

  // Break, delimiter and sync measurement sequence.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_IDLE;
      line_d_reg    <= 1'b1;
      total_reg     <= '0;
      iv_reg        <= '0;
      min_reg       <= '1;
      max_reg       <= '0;
      falls_reg     <= 3'h0;
      ab.sync_error <= 1'b0;
      ab.sync_ok    <= 1'b0;
      ab.period     <= '0;
    end else begin
      line_d_reg    <= ab.line;
      ab.sync_error <= 1'b0;
      ab.sync_ok    <= 1'b0;
      if (!active) begin
        state_reg <= ST_IDLE;
        total_reg <= '0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            if (!ab.line) begin
              if (total_reg != '1) total_reg <= total_reg + 1'b1;
            end else begin
              if (total_reg >= BREAK_MIN) state_reg <= ST_DELIM;
              total_reg <= '0;
            end
          end
          ST_DELIM: begin
            if (fall) begin
              state_reg <= ST_MEASURE;
              total_reg <= '0;
              iv_reg    <= '0;
              min_reg   <= '1;
              max_reg   <= '0;
              falls_reg <= 3'h0;
            end
          end
          ST_MEASURE: begin
            total_reg <= total_reg + 1'b1;
            iv_reg    <= iv_reg + 1'b1;
            if (total_reg > SYNC_MAX) begin
              ab.sync_error <= 1'b1;
              state_reg     <= ST_IDLE;
              total_reg     <= '0;
            end else if (fall) begin
              min_reg   <= min_next;
              max_reg   <= max_next;
              iv_reg    <= '0;
              falls_reg <= falls_reg + 1'b1;
              if (falls_reg == ucc_pkg::LAST_FALL) begin
                ab.sync_error <= bad_len || bad_lin;
                ab.sync_ok    <= !(bad_len || bad_lin);
                ab.period     <= W'(total_reg + 1'b1) >> ucc_pkg::BIT_SHIFT;
                state_reg     <= ST_IDLE;
                total_reg     <= '0;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// File: verilog/ucc_usart_ctrl.sv
// Purpose: Control and configuration registers of a serial transceiver, AXI4-Lite slave.
// Assumes: txd_serial comes from transmitter logic on aclk; pins are asynchronous.
// Notes:   Frame word shows two layouts, chosen by the communication mode field.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module ucc_usart_ctrl #(
  parameter int                        ADDR_W    = 6,
  parameter logic [ucc_pkg::CNT_W-1:0] BREAK_MIN = 20'h0_1000,
  parameter logic [ucc_pkg::CNT_W-1:0] SYNC_MIN  = 20'h0_0040,
  parameter logic [ucc_pkg::CNT_W-1:0] SYNC_MAX  = 20'h8_0000
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rxd_pin,
  input  wire logic              txd_serial,
  input  wire logic              txd_pin_i,
  output logic                   txd_pin_o,
  output logic                   txd_pin_oe,
  output logic                   irq,
  output logic                   line_driver_mode_enable,
  output logic                   receiver_enable,
  output logic                   transmitter_enable,
  output logic                   start_of_frame_detect_enable,
  output logic                   open_drain_enable,
  output logic                   double_speed,
  output logic                   generic_autobaud,
  output logic                   lin_constrained_autobaud,
  output logic                   multiprocessor_mode_enable,
  output logic                   sync_mode,
  output logic                   infrared_mode,
  output logic                   host_spi_mode,
  output logic                   parity_enable,
  output logic                   parity_odd,
  output logic                   tx_two_stop_bits,
  output logic [3:0]             data_bits,
  output logic                   nine_bit_high_first,
  output logic                   lsb_first,
  output logic                   spi_sample_leading_edge
);
  localparam int IW = ADDR_W - 2;

  // Word index must fit the 8-bit index constants and reach the highest one.
  if (ADDR_W < 6 || ADDR_W > 10) begin : g_bad_addr_w
    $error("ADDR_W must lie between 6 and 10");
  end

  ucc_autobaud_if ab ();

  // Bus state.
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [IW-1:0] waddr_reg;
  logic [7:0]    wdata_reg;
  logic          wlane_reg;
  // Configuration and status state.
  logic [7:0]    line_reg;
  logic [7:0]    rxtx_reg;
  logic [1:0]    comm_mode_reg;
  logic [5:0]    frame_reg;
  logic [1:0]    spi_reg;
  logic [7:0]    mask_reg;
  logic          isf_reg;
  logic          bdf_reg;
  logic [ucc_pkg::CNT_W-1:0] period_reg;
  logic [1:0]    rxd_sync_reg;
  logic [1:0]    txdi_sync_reg;
  logic [31:0]   rd_val;
  logic [7:0]    status_vec;
  logic [7:0]    frame_view;

  // True for every index that holds a register.
  function automatic logic reg_known(input logic [7:0] idx);
    reg_known = (idx == ucc_pkg::IDX_STATUS) || (idx == ucc_pkg::IDX_LINE) ||
                (idx == ucc_pkg::IDX_RXTX)   || (idx == ucc_pkg::IDX_FRAME) ||
                (idx == ucc_pkg::IDX_MASK)   || (idx == ucc_pkg::IDX_PERIOD);
  endfunction

  // Data bits per character; reserved sizes fall back to eight.
  function automatic logic [3:0] size_bits(input logic [2:0] chs);
    if (chs == ucc_pkg::CHS_9L || chs == ucc_pkg::CHS_9H) begin
      size_bits = ucc_pkg::BITS_NINE;
    end else if (chs[2]) begin
      size_bits = ucc_pkg::BITS_EIGHT;
    end else begin
      size_bits = ucc_pkg::BITS_BASE + {2'h0, chs[1:0]};
    end
  endfunction

  wire          aw_take = s_axi_awvalid && s_axi_awready;
  wire          w_take  = s_axi_wvalid && s_axi_wready;
  wire          ar_take = s_axi_arvalid && s_axi_arready;
  wire          wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire          wr_ok   = wr_fire && wlane_reg;
  wire [7:0]    wr_idx  = 8'(waddr_reg);
  wire [IW-1:0] rd_word = s_axi_araddr[ADDR_W-1:2];
  wire          is_spi  = (comm_mode_reg == ucc_pkg::CM_SPI);

  // Address and data are taken in either order; a new pair waits for the response.
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_sync_reg  <= 2'h3;
      txdi_sync_reg <= 2'h3;
    end else begin
      rxd_sync_reg  <= {rxd_sync_reg[0], rxd_pin};
      txdi_sync_reg <= {txdi_sync_reg[0], txd_pin_i};
    end
  end

  // Write channel capture and response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ucc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        waddr_reg   <= s_axi_awaddr[ADDR_W-1:2];
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(wr_idx) ? ucc_pkg::RESP_OKAY : ucc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control words; unused bit positions are never stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_reg <= ucc_pkg::LINE_RST;
      rxtx_reg <= ucc_pkg::RXTX_RST;
      mask_reg <= ucc_pkg::MASK_RST;
    end else if (wr_ok) begin
      if (wr_idx == ucc_pkg::IDX_LINE) line_reg <= wdata_reg & ucc_pkg::LINE_WMASK;
      if (wr_idx == ucc_pkg::IDX_RXTX) rxtx_reg <= wdata_reg & ucc_pkg::RXTX_WMASK;
      if (wr_idx == ucc_pkg::IDX_MASK) mask_reg <= wdata_reg & ucc_pkg::STATUS_WMASK;
    end
  end

  // Frame word: the written mode decides which layout the other bits land in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comm_mode_reg <= ucc_pkg::COMM_MODE_RST;
      frame_reg     <= ucc_pkg::FRAME_RST;
      spi_reg       <= ucc_pkg::SPI_RST;
    end else if (wr_ok && wr_idx == ucc_pkg::IDX_FRAME) begin
      comm_mode_reg <= wdata_reg[ucc_pkg::B_COMM_MODE +: 2];
      if (wdata_reg[ucc_pkg::B_COMM_MODE +: 2] == ucc_pkg::CM_SPI) begin
        spi_reg <= {wdata_reg[ucc_pkg::B_DATA_ORDER], wdata_reg[ucc_pkg::B_CLK_PHASE]};
      end else begin
        frame_reg <= wdata_reg[5:0];
      end
    end
  end

  // Sticky status; a hardware set in the clearing cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isf_reg    <= 1'b0;
      bdf_reg    <= 1'b0;
      period_reg <= '0;
    end else begin
      isf_reg <= ab.sync_error ||
                 (isf_reg && !(wr_ok && wr_idx == ucc_pkg::IDX_STATUS &&
                               wdata_reg[ucc_pkg::B_ISF]));
      bdf_reg <= ab.sync_ok ||
                 (bdf_reg && !(wr_ok && wr_idx == ucc_pkg::IDX_STATUS &&
                               wdata_reg[ucc_pkg::B_BDF]));
      if (ab.sync_ok) period_reg <= ab.period;
    end
  end

  // Read views of status and the mode-dependent frame word.
  always_comb begin
    status_vec = 8'h00;
    status_vec[ucc_pkg::B_ISF] = isf_reg;
    status_vec[ucc_pkg::B_BDF] = bdf_reg;
    if (is_spi) begin
      frame_view = {comm_mode_reg, 3'h0, spi_reg, 1'b0};
    end else begin
      frame_view = {comm_mode_reg, frame_reg};
    end
  end

  // Read data; unmapped words read zero with an error response.
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (8'(rd_word))
      ucc_pkg::IDX_STATUS: rd_val[7:0] = status_vec;
      ucc_pkg::IDX_LINE:   rd_val[7:0] = line_reg;
      ucc_pkg::IDX_RXTX:   rd_val[7:0] = rxtx_reg;
      ucc_pkg::IDX_FRAME:  rd_val[7:0] = frame_view;
      ucc_pkg::IDX_MASK:   rd_val[7:0] = mask_reg;
      ucc_pkg::IDX_PERIOD: rd_val[ucc_pkg::CNT_W-1:0] = period_reg;
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ucc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= reg_known(8'(rd_word)) ? ucc_pkg::RESP_OKAY : ucc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt: the auto-baud error also needs its enable in the line word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (isf_reg && mask_reg[ucc_pkg::B_ISF] && line_reg[ucc_pkg::B_AB_ERR_IE]) ||
             (bdf_reg && mask_reg[ucc_pkg::B_BDF]);
    end
  end

  // Auto-baud checker listens on the transmit pin in open-drain one-wire use.
  assign ab.enable  = rxtx_reg[ucc_pkg::B_RX_ENA];
  assign ab.rx_mode = rxtx_reg[ucc_pkg::B_RX_MODE +: 2];
  assign ab.line    = rxtx_reg[ucc_pkg::B_OPEN_DRAIN] ? txdi_sync_reg[1] : rxd_sync_reg[1];

  ucc_autobaud_check #(
    .BREAK_MIN (BREAK_MIN),
    .SYNC_MIN  (SYNC_MIN),
    .SYNC_MAX  (SYNC_MAX)
  ) u_check (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ab      (ab.check)
  );

  // Transmit pin: open-drain only pulls low, so the pin floats high on a one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_pin_o  <= 1'b1;
      txd_pin_oe <= 1'b0;
    end else begin
      txd_pin_o  <= rxtx_reg[ucc_pkg::B_OPEN_DRAIN] ? 1'b0 : txd_serial;
      txd_pin_oe <= rxtx_reg[ucc_pkg::B_TX_ENA] &&
                    (!rxtx_reg[ucc_pkg::B_OPEN_DRAIN] || !txd_serial);
    end
  end

  // Line and receiver/transmitter enables to the datapath.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_driver_mode_enable      <= 1'b0;
      receiver_enable              <= 1'b0;
      transmitter_enable           <= 1'b0;
      start_of_frame_detect_enable <= 1'b0;
      open_drain_enable            <= 1'b0;
      multiprocessor_mode_enable   <= 1'b0;
    end else begin
      line_driver_mode_enable      <= line_reg[ucc_pkg::B_LINE_DRV];
      receiver_enable              <= rxtx_reg[ucc_pkg::B_RX_ENA];
      transmitter_enable           <= rxtx_reg[ucc_pkg::B_TX_ENA];
      start_of_frame_detect_enable <= rxtx_reg[ucc_pkg::B_SOF_DET];
      open_drain_enable            <= rxtx_reg[ucc_pkg::B_OPEN_DRAIN];
      multiprocessor_mode_enable   <= rxtx_reg[ucc_pkg::B_MULTI_PROC];
    end
  end

  // Receiver speed and communication mode decode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      double_speed             <= 1'b0;
      generic_autobaud         <= 1'b0;
      lin_constrained_autobaud <= 1'b0;
      sync_mode                <= 1'b0;
      infrared_mode            <= 1'b0;
      host_spi_mode            <= 1'b0;
    end else begin
      double_speed             <= ab.rx_mode == ucc_pkg::RXM_DOUBLE;
      generic_autobaud         <= ab.rx_mode == ucc_pkg::RXM_GEN;
      lin_constrained_autobaud <= ab.rx_mode == ucc_pkg::RXM_LIN;
      sync_mode                <= comm_mode_reg == ucc_pkg::CM_SYNC;
      infrared_mode            <= comm_mode_reg == ucc_pkg::CM_INFRARED;
      host_spi_mode            <= is_spi;
    end
  end

  // Frame format; in host SPI the hidden frame fields give way to fixed bytes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parity_enable           <= 1'b0;
      parity_odd              <= 1'b0;
      tx_two_stop_bits        <= 1'b0;
      data_bits               <= ucc_pkg::BITS_EIGHT;
      nine_bit_high_first     <= 1'b0;
      lsb_first               <= 1'b1;
      spi_sample_leading_edge <= 1'b0;
    end else begin
      parity_enable           <= !is_spi && frame_reg[ucc_pkg::B_PARITY + 1];
      parity_odd              <= !is_spi && (&frame_reg[ucc_pkg::B_PARITY +: 2]);
      tx_two_stop_bits        <= !is_spi && frame_reg[ucc_pkg::B_STOP_BITS];
      data_bits               <= is_spi ? ucc_pkg::BITS_EIGHT :
                                 size_bits(frame_reg[ucc_pkg::B_CHAR_SIZE +: 3]);
      nine_bit_high_first     <= !is_spi &&
                                 frame_reg[ucc_pkg::B_CHAR_SIZE +: 3] == ucc_pkg::CHS_9H;
      lsb_first               <= is_spi ? spi_reg[1] : 1'b1;
      spi_sample_leading_edge <= is_spi && !spi_reg[0];
    end
  end
endmodule

// File: verif/ucc_line_partner.sv
// Purpose: Remote serial node that sends a break and a 0x55 sync character.
// Assumes: The bit time is given in aclk cycles.
// Notes:   The line idles high, as a pulled-up receive line does.
`timescale 1ns/100ps
module ucc_line_partner (
  input  wire logic aclk,
  output logic      rxd
);
  initial rxd = 1'b1;
  // Break, idle, start bit, 0x55 lsb first; the stop level then stays.
  task automatic send(input int p);
    logic [9:0] f = {1'b1, 8'h55, 1'b0};
    rxd <= 1'b0;
    repeat (20) @(posedge aclk);
    rxd <= 1'b1;
    repeat (4 * p) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (p) @(posedge aclk);
    end
  endtask
endmodule

// File: verif/ucc_usart_ctrl_asserts.sv
// Purpose: Port-level checks of the serial configuration block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the top module; sees its ports only.
`timescale 1ns/100ps
module ucc_usart_ctrl_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       host_spi_mode,
  input wire logic       lsb_first,
  input wire logic       spi_sample_leading_edge,
  input wire logic       parity_enable,
  input wire logic       parity_odd,
  input wire logic [3:0] data_bits,
  input wire logic       open_drain_enable,
  input wire logic       txd_pin_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both halves of a write taken at one edge.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_spi_defaults: assert property (!host_spi_mode |-> lsb_first && !spi_sample_leading_edge)
    else $error("spi order outside spi mode");
  a_spi_parity_off: assert property (host_spi_mode |-> !parity_enable)
    else $error("parity in spi mode");
  a_odd_parity: assert property (parity_odd |-> parity_enable) else $error("odd without parity");
  a_bits_range: assert property (data_bits inside {[5:9]}) else $error("bad data bit count");
  a_drain_low: assert property (open_drain_enable && $past(open_drain_enable) |-> !txd_pin_o)
    else $error("open drain drives high");
endmodule
bind ucc_usart_ctrl ucc_usart_ctrl_asserts i_chk (.*);

// File: verif/usart_control_configuration_bench.sv
// Purpose: Self-checking bench of the configuration block over AXI4-Lite.
// Assumes: Short auto-baud limits; a fixed seed makes runs repeatable.
// Notes:   The transmit pin is pulled up when nobody drives it.
`timescale 1ns/100ps
module usart_control_configuration_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, txd_serial = 1'b1, rxd_pin;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1, data_bits;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd_pin_o, txd_pin_oe, irq;
  logic        line_driver_mode_enable, receiver_enable, transmitter_enable;
  logic        start_of_frame_detect_enable, open_drain_enable, double_speed, generic_autobaud;
  logic        lin_constrained_autobaud, multiprocessor_mode_enable, sync_mode, infrared_mode;
  logic        host_spi_mode, parity_enable, parity_odd, tx_two_stop_bits, nine_bit_high_first;
  logic        lsb_first, spi_sample_leading_edge;
  int          n_errors = 0, n_tests = 0;
  wire logic   txd_pin_i = txd_pin_oe ? txd_pin_o : 1'b1;
  always #2 aclk = ~aclk;
  always @(posedge aclk) txd_serial <= 1'($urandom);
  ucc_usart_ctrl #(.ADDR_W(6), .BREAK_MIN(20'h0_0010), .SYNC_MIN(20'h0_0010),
    .SYNC_MAX(20'h0_1000)) i_dut (.*);
  ucc_line_partner i_line (.aclk(aclk), .rxd(rxd_pin));
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo();
    n_errors++;
    $display("[FAIL] %0t bus wait timed out", $time);
    end_sim();
  endtask
  // Write with both channels offered together; each released once taken.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 64) tmo();
    chk(s_axi_bresp, 2'h0);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 64) tmo();
    chk(s_axi_rdata, {24'h00_0000, e});
    chk(s_axi_rresp, er);
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    #1;
  endtask
  // Expected frame outputs; reserved sizes give eight bits.
  function automatic logic [12:0] fx(input logic [7:0] v);
    logic s;
    s = v[7:6] == 2'h3;
    return {v[7:6] == 2'h1, v[7:6] == 2'h2, s, !s && v[5], !s && v[5:4] == 2'h3, !s && v[3],
      s ? 4'h8 : v[2] ? (v[1] ? 4'h9 : 4'h8) : 4'h5 + {2'h0, v[1:0]},
      !s && v[2:0] == 3'h7, s ? v[2] : 1'b1, s && !v[1]};
  endfunction
  // One sync field, then flag and interrupt, then clearing.
  task automatic ab(input int p, input logic [7:0] st, input logic iq);
    i_line.send(p);
    repeat (20) @(posedge aclk);
    rc(6'h10, st, 2'h0);
    chk(irq, iq);
    wr(6'h10, 8'h0A);
    settle();
    chk(irq, 1'b0);
  endtask
  initial begin
    logic [7:0] v;
    int         k;
    void'($urandom(64717));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 5; k++) rc(6'(16 + 4 * k), k == 3 ? 8'h03 : k == 4 ? 8'h0A : 8'h00, 2'h0);
    rc(6'h3C, 8'h00, 2'h2);
    $display("reset test done");
    // Frame word; no transfer runs while the data order changes.
    for (k = 0; k < 24; k++) begin
      v = k == 0 ? 8'hC6 : k == 1 ? 8'h1F : k == 2 ? 8'h2C : 8'($urandom);
      wr(6'h1C, v);
      settle();
      chk({sync_mode, infrared_mode, host_spi_mode, parity_enable, parity_odd,
        tx_two_stop_bits, data_bits, nine_bit_high_first, lsb_first,
        spi_sample_leading_edge}, fx(v));
      rc(6'h1C, v[7:6] == 2'h3 ? {5'h18, v[2:1], 1'b0} : v, 2'h0);
    end
    $display("frame test done");
    wr(6'h1C, 8'h43);
    for (k = 0; k < 16; k++) begin
      v = 8'($urandom);
      wr(6'h18, v);
      settle();
      chk({receiver_enable, transmitter_enable, start_of_frame_detect_enable,
        open_drain_enable, double_speed, generic_autobaud, lin_constrained_autobaud,
        multiprocessor_mode_enable}, {v[7:6], v[4:3], v[2:1] == 2'h1, v[2:1] == 2'h2,
        v[2:1] == 2'h3, v[0]});
      if (!v[3]) chk(txd_pin_oe, v[6]);
      rc(6'h18, v & 8'hDF, 2'h0);
    end
    wr(6'h14, 8'hFF);
    settle();
    chk(line_driver_mode_enable, 1'b1);
    rc(6'h14, 8'h05, 2'h0);
    $display("control test done");
    wr(6'h10, 8'h0A);
    wr(6'h14, 8'h04);
    wr(6'h18, 8'h84);
    ab(8, 8'h02, 1'b1);
    rc(6'h24, 8'h08, 2'h0);
    ab(1, 8'h08, 1'b1);
    wr(6'h14, 8'h00);
    ab(1, 8'h08, 1'b0);
    $display("autobaud test done");
    end_sim();
  end
endmodule
